// ---- inc/csie_pkg.sv ----
package csie_pkg;

    // ======================================================
    // register byte offsets on the 32-bit apb bus
    // ======================================================
    localparam logic [7:0] OFS_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
    localparam logic [7:0] OFS_CLK_SEL = 8'h08;
    localparam logic [7:0] OFS_PLL_CTL = 8'h0c;

    // ======================================================
    // field positions
    // ======================================================
    // flags register
    localparam int BIT_TICK_FLAG   = 7;
    localparam int BIT_SETTLE_FLAG = 4;
    localparam int BIT_LOCK        = 3;
    localparam int BIT_TRACK       = 2;
    localparam int BIT_SELF_FLAG   = 1;
    localparam int BIT_SELF_CLK    = 0;
    // clock_irq_enable register
    localparam int BIT_TICK_IE     = 7;
    localparam int BIT_SETTLE_IE   = 4;
    localparam int BIT_SELF_IE     = 1;
    // clock_source_select register
    localparam int BIT_PLL_CHOOSE  = 7;
    localparam int BIT_PSEUDO_HALT = 6;
    localparam int BIT_SYS_HALT_W  = 5;
    localparam int BIT_REDUCED_W   = 4;
    localparam int BIT_PLL_HALT_W  = 3;
    localparam int BIT_CORE_HALT_W = 2;
    localparam int BIT_TICK_HALT_W = 1;
    localparam int BIT_WDOG_HALT_W = 0;
    // pll control register
    localparam int BIT_AUTO_BW     = 5;

    // ======================================================
    // reset values and fixed ratios
    // ======================================================
    localparam logic [7:0] RST_IRQ_EN  = 8'h00;
    localparam logic [7:0] RST_CLK_SEL = 8'h00;
    localparam logic       RST_AUTO_BW = 1'b1;
    localparam int         BUS_DIV     = 2;  // bus clock = source / 2

    // event flag slots
    localparam int EV_TICK   = 0;
    localparam int EV_SETTLE = 1;
    localparam int EV_SELF   = 2;
    localparam int EV_NUM    = 3;

    // address decode shared by the read mux and the write path
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == OFS_FLAGS) || (a == OFS_IRQ_EN) ||
                     (a == OFS_CLK_SEL) || (a == OFS_PLL_CTL);
    endfunction : reg_mapped

endpackage : csie_pkg

// ---- inc/csie_reg_if.sv ----
`timescale 1ns/1ps
// register access between the bus slave and the register file
interface csie_reg_if;
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       mapped;

    modport bus_side  (output wr_stb, addr, wdata, input rdata, mapped);
    modport regs_side (input wr_stb, addr, wdata, output rdata, mapped);
endinterface : csie_reg_if

// ---- hw/csie_apb_slave.sv ----
`timescale 1ns/1ps
module csie_apb_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    csie_reg_if.bus_side     regs
);
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;

    assign regs.addr  = paddr_i;
    assign regs.wdata = pwdata_i[7:0];
    // write lands only at the edge that completes the access
    assign regs.wr_stb = psel_i & penable_i & pready_q & pwrite_i
                         & regs.mapped;

    // ======================================================
    // answer: one access cycle, all outputs registered
    // ======================================================
    // read data and error are captured at the end of setup
    always_comb begin
        pready_d  = psel_i & ~penable_i;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (psel_i && !penable_i) begin
            prdata_d  = (pwrite_i || !regs.mapped) ? 32'h0000_0000
                                                   : {24'h00_0000, regs.rdata};
            pslverr_d = ~regs.mapped;
        end else if (!psel_i) begin
            pslverr_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
endmodule : csie_apb_slave

// ---- hw/csie_event_flags.sv ----
`timescale 1ns/1ps
module csie_event_flags #(
    parameter int N = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] flag_o
);
    logic [N-1:0] flag_q, flag_d;

    // ======================================================
    // sticky flags, cleared by writing one
    // ======================================================
    // set beats clear so an event in the clear cycle is kept
    always_comb begin
        for (int i = 0; i < N; i++) begin
            flag_d[i] = set_i[i] | (flag_q[i] & ~clr_i[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule : csie_event_flags

// ---- hw/csie_top.sv ----
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - tick flag with enable raises interrupt
// - settle change flag with enable raises interrupt
// - self-clocked change flag with enable interrupts
// - enable register readable and writable anytime
// - pll choose write stores zero when pll unstable
// - pll choose cleared in self-clock, stop, and wait with pll halt set
// - choose selects oscillator or pll, bus halves
// - pseudo halt keeps oscillator reduced in stop
// - system clocks halt in wait when set
// - reduced amplitude in wait when set
// - pll powered down in wait, power bit kept
// - pll halt in wait forces auto bandwidth
// - core clock halts in wait when set
// - tick timer halts, dividers clear on wait entry
// - watchdog halts, dividers clear on wait entry
// - watchdog halt bit write once in normal modes
// - tick flag set per period, write-one clears
// - settle flag set on lock change, w1c
// - self-clocked flag set on mode change, w1c
module csie_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // status from pll, tick timer and mode logic
    input  wire logic        pll_locked_i,
    input  wire logic        pll_tracking_i,
    input  wire logic        self_clocked_mode_i,
    input  wire logic        tick_timeout_i,
    input  wire logic        wait_mode_i,
    input  wire logic        stop_mode_i,
    input  wire logic        special_mode_i,
    // clock control
    output logic             irq_o,
    output logic             pll_source_choose_o,
    output logic             oscillator_enable_o,
    output logic             oscillator_reduced_o,
    output logic             system_clocks_run_o,
    output logic             core_clock_run_o,
    output logic             pll_power_down_o,
    output logic             auto_bandwidth_o,
    output logic             tick_run_o,
    output logic             tick_div_clear_o,
    output logic             watchdog_run_o,
    output logic             watchdog_div_clear_o
);

    // ======================================================
    // bus slave and register access
    // ======================================================
    csie_reg_if regs ();

    csie_apb_slave u_apb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .regs      (regs.bus_side)
    );

    // write strobes per register
    logic wr_flags;
    logic wr_irq_en;
    logic wr_clk_sel;
    logic wr_pll_ctl;

    assign regs.mapped = csie_pkg::reg_mapped(regs.addr);
    assign wr_flags    = regs.wr_stb && (regs.addr == csie_pkg::OFS_FLAGS);
    assign wr_irq_en   = regs.wr_stb && (regs.addr == csie_pkg::OFS_IRQ_EN);
    assign wr_clk_sel  = regs.wr_stb && (regs.addr == csie_pkg::OFS_CLK_SEL);
    assign wr_pll_ctl  = regs.wr_stb && (regs.addr == csie_pkg::OFS_PLL_CTL);

    // ======================================================
    // status change detection
    // ======================================================
    // previous levels; the flag is raised on any change
    logic lock_prev_q, lock_prev_d;
    logic self_prev_q, self_prev_d;
    logic wait_prev_q, wait_prev_d;
    logic wait_entry;

    always_comb begin
        lock_prev_d = pll_locked_i;
        self_prev_d = self_clocked_mode_i;
        wait_prev_d = wait_mode_i;
    end

    // lock reads low after reset, so an early lock is also a change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_prev_q <= 1'b0;
            self_prev_q <= 1'b0;
            wait_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= lock_prev_d;
            self_prev_q <= self_prev_d;
            wait_prev_q <= wait_prev_d;
        end
    end

    assign wait_entry = wait_mode_i & ~wait_prev_q;

    // ======================================================
    // sticky event flags
    // ======================================================
    logic [csie_pkg::EV_NUM-1:0] ev_set;
    logic [csie_pkg::EV_NUM-1:0] ev_clr;
    logic [csie_pkg::EV_NUM-1:0] ev_flag;

    always_comb begin
        ev_set[csie_pkg::EV_TICK]   = tick_timeout_i;
        ev_set[csie_pkg::EV_SETTLE] = pll_locked_i ^ lock_prev_q;
        ev_set[csie_pkg::EV_SELF]   = self_clocked_mode_i
                                      ^ self_prev_q;
        // writing zero to a flag leaves it alone
        ev_clr[csie_pkg::EV_TICK]   = wr_flags
            & regs.wdata[csie_pkg::BIT_TICK_FLAG];
        ev_clr[csie_pkg::EV_SETTLE] = wr_flags
            & regs.wdata[csie_pkg::BIT_SETTLE_FLAG];
        ev_clr[csie_pkg::EV_SELF]   = wr_flags
            & regs.wdata[csie_pkg::BIT_SELF_FLAG];
    end

    csie_event_flags #(
        .N (csie_pkg::EV_NUM)
    ) u_flags (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (ev_set),
        .clr_i  (ev_clr),
        .flag_o (ev_flag)
    );

    // ======================================================
    // clock_irq_enable register
    // ======================================================
    logic [7:0] irq_en_q, irq_en_d;
    logic [7:0] irq_en_mask;

    // only the three enable bits are kept, the rest read zero
    assign irq_en_mask = 8'h92;

    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_irq_en) begin
            irq_en_d = regs.wdata & irq_en_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= csie_pkg::RST_IRQ_EN;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // ======================================================
    // pll control: automatic bandwidth
    // ======================================================
    logic       auto_bw_q, auto_bw_d;
    logic       pll_halt_w;
    logic [7:0] clk_sel_q, clk_sel_d;

    assign pll_halt_w = clk_sel_q[csie_pkg::BIT_PLL_HALT_W];

    // software write is overridden whenever the pll halt in wait bit is set, in or out of wait
    always_comb begin
        auto_bw_d = auto_bw_q;
        if (pll_halt_w) begin
            auto_bw_d = 1'b1;
        end else if (wr_pll_ctl) begin
            auto_bw_d = regs.wdata[csie_pkg::BIT_AUTO_BW];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_bw_q <= csie_pkg::RST_AUTO_BW;
        end else begin
            auto_bw_q <= auto_bw_d;
        end
    end

    // ======================================================
    // clock_source_select register
    // ======================================================
    logic       wdog_locked_q, wdog_locked_d;
    logic       pll_stable;
    logic       force_osc;

    // the effective auto bit counts, forced or not
    assign pll_stable = (auto_bw_q | pll_halt_w) ? pll_locked_i
                                                  : pll_tracking_i;
    // conditions that drop the pll back to the oscillator
    assign force_osc = self_clocked_mode_i | stop_mode_i
                       | (wait_mode_i & pll_halt_w);

    always_comb begin
        clk_sel_d     = clk_sel_q;
        wdog_locked_d = wdog_locked_q;
        if (wr_clk_sel) begin
            // a one is refused while the pll is unsettled
            clk_sel_d[csie_pkg::BIT_PLL_CHOOSE] =
                regs.wdata[csie_pkg::BIT_PLL_CHOOSE] & pll_stable;
            clk_sel_d[6:1] = regs.wdata[6:1];
            if (special_mode_i || !wdog_locked_q) begin
                clk_sel_d[csie_pkg::BIT_WDOG_HALT_W] =
                    regs.wdata[csie_pkg::BIT_WDOG_HALT_W];
            end
            wdog_locked_d = 1'b1;
        end
        // hardware clear wins over a write in the same cycle
        if (force_osc) begin
            clk_sel_d[csie_pkg::BIT_PLL_CHOOSE] = 1'b0;
        end
        // no automatic re-choose after wait; software must do it
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_q     <= csie_pkg::RST_CLK_SEL;
            wdog_locked_q <= 1'b0;
        end else begin
            clk_sel_q     <= clk_sel_d;
            wdog_locked_q <= wdog_locked_d;
        end
    end

    // ======================================================
    // read mux
    // ======================================================
    always_comb begin
        case (regs.addr)
            csie_pkg::OFS_FLAGS: begin
                regs.rdata = {ev_flag[csie_pkg::EV_TICK], 2'b00,
                              ev_flag[csie_pkg::EV_SETTLE],
                              pll_locked_i, pll_tracking_i,
                              ev_flag[csie_pkg::EV_SELF],
                              self_clocked_mode_i};
            end
            csie_pkg::OFS_IRQ_EN: begin
                regs.rdata = irq_en_q;
            end
            csie_pkg::OFS_CLK_SEL: begin
                regs.rdata = clk_sel_q;
            end
            csie_pkg::OFS_PLL_CTL: begin
                regs.rdata = {2'b00, auto_bw_q | pll_halt_w, 5'h00};
            end
            default: begin
                regs.rdata = 8'h00;
            end
        endcase
    end

    // ======================================================
    // clock control outputs, all registered
    // ======================================================
    logic [11:0] ctl_q, ctl_d;
    logic        in_wait;

    assign in_wait = wait_mode_i;

    // one flop per output keeps glitches off the clock gates
    always_comb begin
        ctl_d[0]  = |(ev_flag & {irq_en_q[csie_pkg::BIT_SELF_IE],
                                 irq_en_q[csie_pkg::BIT_SETTLE_IE],
                                 irq_en_q[csie_pkg::BIT_TICK_IE]});
        // mux select only; the halving lives in the clock tree
        ctl_d[1]  = clk_sel_d[csie_pkg::BIT_PLL_CHOOSE];
        ctl_d[2]  = ~(stop_mode_i
                      & ~clk_sel_q[csie_pkg::BIT_PSEUDO_HALT]);
        ctl_d[3]  = (stop_mode_i & clk_sel_q[csie_pkg::BIT_PSEUDO_HALT])
                    | (in_wait & clk_sel_q[csie_pkg::BIT_REDUCED_W]);
        ctl_d[4]  = ~(in_wait & clk_sel_q[csie_pkg::BIT_SYS_HALT_W]);
        ctl_d[5]  = ~(in_wait & clk_sel_q[csie_pkg::BIT_CORE_HALT_W]);
        ctl_d[6]  = in_wait & pll_halt_w;
        ctl_d[7]  = auto_bw_d;
        // tick and watchdog ignore the system-clock halt bit
        ctl_d[8]  = ~(in_wait & clk_sel_q[csie_pkg::BIT_TICK_HALT_W]);
        ctl_d[9]  = wait_entry & clk_sel_q[csie_pkg::BIT_TICK_HALT_W];
        ctl_d[10] = ~(in_wait & clk_sel_q[csie_pkg::BIT_WDOG_HALT_W]);
        ctl_d[11] = wait_entry & clk_sel_q[csie_pkg::BIT_WDOG_HALT_W];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 12'h5b4;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign irq_o                = ctl_q[0];
    assign pll_source_choose_o  = ctl_q[1];
    assign oscillator_enable_o  = ctl_q[2];
    assign oscillator_reduced_o = ctl_q[3];
    assign system_clocks_run_o  = ctl_q[4];
    assign core_clock_run_o     = ctl_q[5];
    assign pll_power_down_o     = ctl_q[6];
    assign auto_bandwidth_o     = ctl_q[7];
    assign tick_run_o           = ctl_q[8];
    assign tick_div_clear_o     = ctl_q[9];
    assign watchdog_run_o       = ctl_q[10];
    assign watchdog_div_clear_o = ctl_q[11];

endmodule : csie_top

// ---- testbench/csie_checker.sv ----
`timescale 1ns/1ps
// =====
// bus and clock control checks
module csie_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic self_clocked_mode_i,
    input wire logic pready_o,
    input wire logic pll_source_choose_o,
    input wire logic oscillator_enable_o,
    input wire logic system_clocks_run_o,
    input wire logic core_clock_run_o,
    input wire logic pll_power_down_o,
    input wire logic auto_bandwidth_o,
    input wire logic tick_div_clear_o,
    input wire logic watchdog_div_clear_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // answer one cycle after setup, never stretched
    chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    chk_ready_once: assert property ($rose(pready_o) |=> !pready_o)
        else $error("pready held too long");
    // two cycles of slack for the mirrored select bit
    chk_stop_drop: assert property (stop_mode_i [*2] |=> !pll_source_choose_o)
        else $error("pll choice kept in stop");
    chk_self_drop: assert property
        (self_clocked_mode_i [*2] |=> !pll_source_choose_o)
        else $error("pll choice kept in self clock");
    chk_osc_run: assert property (!stop_mode_i |=> oscillator_enable_o)
        else $error("oscillator off outside stop");
    chk_auto_held: assert property (pll_power_down_o |-> auto_bandwidth_o)
        else $error("auto bandwidth not forced");
    chk_pd_wait: assert property (pll_power_down_o |-> $past(wait_mode_i))
        else $error("pll down outside wait");
    // tick divider clear only on a fresh wait entry, watchdog clear single cycle
    chk_tick_pulse: assert property (tick_div_clear_o |->
        $past(wait_mode_i) && !$past(wait_mode_i, 2))
        else $error("tick clear without wait entry");
    chk_wd_pulse: assert property
        (watchdog_div_clear_o |=> !watchdog_div_clear_o)
        else $error("watchdog clear too long");
    chk_run_awake: assert property (!wait_mode_i |=>
        core_clock_run_o && system_clocks_run_o)
        else $error("clocks halted outside wait");
endmodule : csie_checker

bind csie_top csie_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
    .self_clocked_mode_i(self_clocked_mode_i), .pready_o(pready_o),
    .pll_source_choose_o(pll_source_choose_o),
    .oscillator_enable_o(oscillator_enable_o),
    .system_clocks_run_o(system_clocks_run_o),
    .core_clock_run_o(core_clock_run_o),
    .pll_power_down_o(pll_power_down_o),
    .auto_bandwidth_o(auto_bandwidth_o),
    .tick_div_clear_o(tick_div_clear_o),
    .watchdog_div_clear_o(watchdog_div_clear_o)
);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
// =====
// bench with register and flag model
module tb_top;
    logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, err, lk;
    logic [7:0]  paddr_i, ien, sel, flg, r;
    logic [31:0] pwdata_i, prdata_o, rdv;
    logic        pready_o, pslverr_o, irq_o, pll_locked_i, pll_tracking_i;
    logic        self_clocked_mode_i, tick_timeout_i, wait_mode_i;
    logic        stop_mode_i, special_mode_i, autob, wdlk;
    wire  [8:0]  ctl;
    wire  [1:0]  clr;
    int          fails, checks, seed, cyc;

    csie_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pll_locked_i(pll_locked_i),
        .pll_tracking_i(pll_tracking_i),
        .self_clocked_mode_i(self_clocked_mode_i),
        .tick_timeout_i(tick_timeout_i), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .special_mode_i(special_mode_i),
        .irq_o(irq_o), .pll_source_choose_o(ctl[8]),
        .oscillator_enable_o(ctl[7]), .oscillator_reduced_o(ctl[6]),
        .system_clocks_run_o(ctl[5]), .core_clock_run_o(ctl[4]),
        .pll_power_down_o(ctl[3]), .auto_bandwidth_o(ctl[2]),
        .tick_run_o(ctl[1]), .watchdog_run_o(ctl[0]),
        .tick_div_clear_o(clr[1]), .watchdog_div_clear_o(clr[0])
    );

    // =====
    // clock and hang guard
    initial begin
        clk_i = 0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            test_done();
        end
    end

    // =====
    // shared tasks
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // one apb transfer, held until pready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i   <= 1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1);
        rdv = prdata_o;
        err = pslverr_o;
        psel_i    <= 0;
        penable_i <= 0;
        cmp("access", 32'h1, n);
        cmp("pslverr", {31'h0, !(a inside {8'h00, 8'h04, 8'h08, 8'h0c})},
            {31'h0, err});
    endtask : apb

    // write and mirror the effect into the model
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1, a, d);
        case (a)
            8'h00: flg = flg & ~(d & 8'h92); // w1c
            8'h04: ien = d & 8'h92; // enables
            8'h08: begin
                if (wdlk && !special_mode_i) d[0] = sel[0]; // once
                wdlk = wdlk | !special_mode_i;
                if (!((autob | sel[3]) ? pll_locked_i : pll_tracking_i))
                    d[7] = d[7] & sel[7]; // gate
                sel = d;
                autob = autob | sel[3]; // forced
            end
            8'h0c: autob = d[5] | sel[3]; // forced
            default: ;
        endcase
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
            input string nm);
        apb(0, a, 8'h00);
        cmp(nm, {24'h0, e & m}, rdv & {24'h0, m});
    endtask : rd

    task rflags;
        rd(8'h00, {flg[7], 2'b0, flg[4], pll_locked_i, pll_tracking_i,
                   flg[1], self_clocked_mode_i}, 8'hff, "flags");
    endtask : rflags

    // expected clock controls and interrupt line
    task outs;
        logic [8:0] e;
        e = {sel[7], !(stop_mode_i && !sel[6]),
             (stop_mode_i && sel[6]) || (wait_mode_i && sel[4]),
             !(wait_mode_i && sel[5]), !(wait_mode_i && sel[2]),
             wait_mode_i && sel[3], autob | sel[3],
             !(wait_mode_i && sel[1]), !(wait_mode_i && sel[0])};
        cmp("ctl", {23'h0, e}, {23'h0, ctl});
        cmp("irq", {31'h0, |(flg & ien)}, {31'h0, irq_o}); // or
    endtask : outs

    // tick pulse, lock toggle or a three-cycle self-clock spell
    task fire(input int k);
        @(posedge clk_i);
        if (k == 0) tick_timeout_i <= 1;
        if (k == 1) pll_locked_i <= !pll_locked_i;
        if (k == 2) self_clocked_mode_i <= 1;
        flg = flg | (k == 0 ? 8'h80 : k == 1 ? 8'h10 : 8'h02);
        @(posedge clk_i);
        tick_timeout_i <= 0;
        repeat (2) @(posedge clk_i);
        self_clocked_mode_i <= 0;
        if (k == 2) sel[7] = 0; // drop
        repeat (3) @(negedge clk_i);
    endtask : fire

    // =====
    // main sequence
    initial begin
        seed = 25647;
        {fails, checks, cyc} = '0;
        {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        rst_i = 1;
        {pll_locked_i, pll_tracking_i, self_clocked_mode_i} = '0;
        {tick_timeout_i, wait_mode_i, stop_mode_i, special_mode_i} = '0;
        {ien, sel, flg, wdlk} = '0;
        autob = 1;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        outs(); // idle
        rd(8'h04, 8'h00, 8'hff, "irq_en"); // reset
        rd(8'h08, 8'h00, 8'hff, "clk_sel"); // reset
        rd(8'h0c, 8'h20, 8'h20, "auto_bw"); // reset
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00, 8'hff, "unmapped");
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, 8'($random(seed))); // random
            rd(8'h04, ien, 8'hff, "irq_en"); // echo
        end
        wr(8'h08, 8'h01); // first
        wr(8'h08, 8'h00); // later
        rd(8'h08, sel, 8'hff, "clk_sel"); // kept
        for (int k = 0; k < 3; k++) begin
            wr(8'h04, 8'h00);
            fire(k);
            rflags(); // set
            outs(); // masked
            wr(8'h04, 8'h92);
            repeat (2) @(negedge clk_i);
            outs(); // raised
            wr(8'h00, 8'h00);
            rflags(); // kept
            wr(8'h00, 8'h92);
            repeat (2) @(negedge clk_i);
            rflags(); // cleared
            outs(); // quiet
        end
        for (int j = 0; j < 4; j++) begin
            lk = (j == 1 || j == 2);
            @(posedge clk_i);
            if (pll_locked_i != lk) flg[4] = 1;
            pll_locked_i   <= lk;
            pll_tracking_i <= !lk;
            wr(8'h0c, {2'b0, j < 2, 5'h0});
            wr(8'h08, 8'h00);
            wr(8'h08, 8'h80); // stability
            repeat (2) @(negedge clk_i);
            outs(); // source
        end
        @(posedge clk_i);
        pll_locked_i <= 1;
        flg[4] = 1;
        wr(8'h0c, 8'h20);
        for (int p = 0; p < 2; p++) begin
            wr(8'h08, {1'b1, p[0], 6'h01});
            @(posedge clk_i) stop_mode_i <= 1;
            sel[7] = 0; // stop
            repeat (3) @(negedge clk_i);
            outs(); // stop
            @(posedge clk_i) stop_mode_i <= 0;
            repeat (2) @(negedge clk_i);
            outs(); // no restore
        end
        wr(8'h08, 8'h81);
        fire(2);
        outs(); // self clock
        wr(8'h0c, 8'h00);
        @(posedge clk_i) special_mode_i <= 1;
        for (int i = 0; i < 6; i++) begin
            r = 8'($random(seed));
            wr(8'h08, {1'b1, r[6:4], i[0], r[2:0]});
            @(posedge clk_i) wait_mode_i <= 1;
            if (sel[3]) sel[7] = 0; // wait
            repeat (2) @(negedge clk_i);
            cmp("div_clr", {30'h0, sel[1:0]}, {30'h0, clr});
            @(negedge clk_i);
            cmp("div_clr", 32'h0, {30'h0, clr}); // single
            outs(); // wait
            rd(8'h0c, {2'b0, autob | sel[3], 5'h0}, 8'h20, "auto");
            @(posedge clk_i) wait_mode_i <= 0;
            repeat (2) @(negedge clk_i);
            outs(); // after wait
        end
        test_done();
    end
endmodule : tb_top
